// [logic/emspf_pkg.sv]
// Shared constants, encodings and carrier types of the expanded-memory page mapper.
`default_nettype none
package emspf_pkg;
    // I/O port addresses of the block.
    localparam logic [15:0] CTRL_PORT = 16'h6872;
    localparam logic [15:0] PTR_PORT = 16'hE072;
    localparam logic [15:0] PAGE_PORT = 16'hE872;
    localparam logic [15:0] TEST_PORT = 16'hA872;

    // Field positions of the control port.
    localparam int CTRL_INC_BIT = 15;
    localparam int CTRL_LOC_HI = 14;
    localparam int CTRL_LOC_LO = 13;
    localparam int CTRL_EN_HI = 11;
    localparam int CTRL_EN_LO = 10;
    localparam int CTRL_APPLY_BIT = 7;
    localparam int CTRL_RSV_HI = 6;
    localparam int CTRL_RSV_LO = 0;

    // Field positions of the test, pointer and page ports.
    localparam int TEST_TRIG_BIT = 8;
    localparam int PTR_HI = 5;
    localparam int PTR_LO = 0;
    localparam int TAP_HI = 15;
    localparam int TAP_LO = 6;
    localparam int TAP_W = 10;
    localparam int PAGE_EN_BIT = 15;
    localparam int PAGE_RO_HI = 14;
    localparam int PAGE_RO_LO = 12;
    localparam int PAGE_EXT_BIT = 11;
    localparam int PAGE_NUM_HI = 11;
    localparam int PAGE_NUM_LO = 0;

    // Address layout of memory cycles.
    localparam int ADDR_W = 24;
    localparam int OFF_W = 14;
    localparam int WIN_HI = 19;
    localparam int WIN_LO = 14;
    localparam int HIGH_HI = 23;
    localparam int HIGH_LO = 20;
    localparam int RSV_ADDR_HI = 23;
    localparam int RSV_ADDR_LO = 17;
    localparam int PHYS_W = 26;

    // Window numbers, in 16 Kbyte units, and page register numbers.
    localparam logic [6:0] UPPER_BASE_WIN = 7'h31;
    localparam logic [6:0] FRAME_SLOTS = 7'h08;
    localparam logic [5:0] UPPER_ANCHOR_WIN = 6'h38;
    localparam logic [5:0] UPPER_FIRST_REG = 6'h20;
    localparam logic [5:0] LOWER_FIRST_WIN = 6'h08;
    localparam logic [5:0] LOWER_LAST_WIN = 6'h1F;
    localparam logic [5:0] LOW_BANK_FIRST_WIN = 6'h20;
    localparam logic [5:0] LOW_BANK_LAST_WIN = 6'h27;
    localparam int PAGE_REGS_DEF = 40;
    localparam int UPPER_RESET_BASE = 32;

    // Frame enable field encodings.
    typedef enum logic [1:0] {
        EMSPF_OFF = 2'h0,
        EMSPF_PROG = 2'h1,
        EMSPF_UPPER = 2'h2,
        EMSPF_ALL = 2'h3
    } emspf_frame_en_t;

    // Host I/O cycle.
    typedef struct packed {
        logic rd;
        logic wr;
        logic [15:0] addr;
        logic [15:0] wdata;
    } emspf_io_req_t;

    // Host memory cycle.
    typedef struct packed {
        logic valid;
        logic [ADDR_W-1:0] addr;
    } emspf_mem_req_t;

    // Translation result of one memory cycle.
    typedef struct packed {
        logic valid;
        logic hit;
        logic external;
        logic reserved;
        logic [PHYS_W-1:0] phys;
    } emspf_map_t;

    // Whole state of the mapper.
    typedef struct packed {
        logic inc;
        logic [1:0] base_sel;
        emspf_frame_en_t frame_en;
        logic apply;
        logic [6:0] rsv;
        logic test_trig;
        logic [5:0] ptr;
        logic rd_go;
        logic rd_page;
        logic [15:0] rd_hold;
        logic [15:0] rdata;
        logic rvalid;
        logic m_valid;
        logic m_upper;
        logic m_lower;
        logic m_rsv;
        logic [OFF_W-1:0] m_off;
        emspf_map_t map;
    } emspf_state_t;
endpackage : emspf_pkg
`default_nettype wire

// [logic/emspf_page_mem.sv]
// Page register storage with one write port and two registered read ports.
`timescale 1ns/1ps
`default_nettype none
module emspf_page_mem #(
    parameter int DEPTH = 40,
    parameter int WIDTH = 16,
    parameter int AW = 6,
    parameter int RESET_BASE = 32
) (
    input wire logic i_clk,
    input wire logic i_sys_rst,
    input wire logic i_we,
    input wire logic [AW-1:0] i_waddr,
    input wire logic [WIDTH-1:0] i_wdata,
    input wire logic [AW-1:0] i_host_addr,
    output logic [WIDTH-1:0] o_host_data,
    input wire logic [AW-1:0] i_map_addr,
    output logic [WIDTH-1:0] o_map_data
);
    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] cells;
        logic [WIDTH-1:0] host_q;
        logic [WIDTH-1:0] map_q;
    } emspf_mem_state_t;

    emspf_mem_state_t state_reg;
    emspf_mem_state_t state_next;

    if (DEPTH < 1 || DEPTH > (1 << AW) || RESET_BASE > DEPTH) begin : g_bad
        $error("emspf_page_mem: depth does not fit the address width");
    end

    // Only the entries from the reset base upward are cleared by reset.
    always_comb begin
        state_next = state_reg;
        if (i_sys_rst) begin
            for (int i = RESET_BASE; i < DEPTH; i++) begin
                state_next.cells[i] = '0;
            end
            state_next.host_q = '0;
            state_next.map_q = '0;
        end else begin
            if (i_we && (int'(i_waddr) < DEPTH)) begin
                state_next.cells[i_waddr] = i_wdata;
            end
            state_next.host_q = (int'(i_host_addr) < DEPTH) ? state_reg.cells[i_host_addr] : '0;
            state_next.map_q = (int'(i_map_addr) < DEPTH) ? state_reg.cells[i_map_addr] : '0;
        end
    end

    always_ff @(posedge i_clk) begin
        state_reg <= state_next;
    end

    assign o_host_data = state_reg.host_q;
    assign o_map_data = state_reg.map_q;
endmodule : emspf_page_mem
`default_nettype wire

// [logic/emspf_frame_dec.sv]
// Decodes a memory address into an upper or lower page frame window and its page register.
`timescale 1ns/1ps
`default_nettype none
module emspf_frame_dec (
    input wire logic [emspf_pkg::ADDR_W-1:0] i_addr,
    input wire logic [1:0] i_base_select,
    output logic o_upper,
    output logic o_lower,
    output logic [5:0] o_index
);
    logic [5:0] win;
    logic below_1m;
    logic [6:0] base;
    logic [6:0] win_ext;
    logic [2:0] slot;

    always_comb begin
        win = i_addr[emspf_pkg::WIN_HI:emspf_pkg::WIN_LO];
        below_1m = (i_addr[emspf_pkg::HIGH_HI:emspf_pkg::HIGH_LO] == 4'h0);
        win_ext = {1'b0, win};
        base = emspf_pkg::UPPER_BASE_WIN + {5'h00, i_base_select};
        slot = win[2:0] - emspf_pkg::UPPER_ANCHOR_WIN[2:0];
        o_upper = below_1m && (win_ext >= base) && (win_ext < base + emspf_pkg::FRAME_SLOTS);
        o_lower = 1'b0;
        o_index = 6'h00;
        if (o_upper) begin
            o_index = emspf_pkg::UPPER_FIRST_REG + {3'h0, slot};
        end else if (below_1m && win >= emspf_pkg::LOWER_FIRST_WIN
                     && win <= emspf_pkg::LOWER_LAST_WIN) begin
            o_lower = 1'b1;
            o_index = win;
        end else if (below_1m && win >= emspf_pkg::LOW_BANK_FIRST_WIN
                     && win <= emspf_pkg::LOW_BANK_LAST_WIN) begin
            o_lower = 1'b1;
            o_index = win - emspf_pkg::LOW_BANK_FIRST_WIN;
        end
    end
endmodule : emspf_frame_dec
`default_nettype wire

// [logic/emspf_mapper.sv]
// Expanded-memory page frame mapper: control ports, page register pointer and frame translation.
`timescale 1ns/1ps
`default_nettype none
// What this block does
// - Boundary field bits 6..0 stand for address bits 23..17 of the expanded start.
// - The pointer indirectly selects which of forty page registers the page port reaches.
// - With increment set, the pointer advances after each page port read or write while the enable field is not off.
// - Pointer bits 5..0 are read-write; bits 15..6 are read-only, writes ignored.
// - In delay test mode, pointer bits 15..6 show the delay tap state.
// - Delay test mode follows bit 8 of the test enable port.
// - Upper windows map to register 32 plus window minus 38h, modulo eight.
// - Lower windows 20000h-7FFFFh map to 8..31, 80000h-9FFFFh to 0..7.
// - Upper registers 32..39 are each gated by their own enable bit 15.
// - Registers 0..31 are enabled as a group when the enable field is 11.
// - Enable field: off, programming only, upper frames, upper and lower frames.
// - Base select picks the upper block start at C4000h, C8000h, CC000h or D0000h.
// - The boundary reserves memory above it only while its apply bit is set.
// - A frame hit yields page number times 16 Kbyte plus the low 14 address bits.
module emspf_mapper #(
    parameter int PAGE_REGS = emspf_pkg::PAGE_REGS_DEF
) (
    input wire logic i_clk,
    input wire logic i_sys_rst,
    input wire emspf_pkg::emspf_io_req_t i_io,
    output logic [15:0] o_io_rdata,
    output logic o_io_rvalid,
    input wire emspf_pkg::emspf_mem_req_t i_mem,
    output var emspf_pkg::emspf_map_t o_map,
    input wire logic [emspf_pkg::TAP_W-1:0] i_delay_tap_state,
    output logic o_delay_test_trigger
);
    localparam logic [6:0] REGS_N = 7'(PAGE_REGS);

    if (PAGE_REGS < emspf_pkg::PAGE_REGS_DEF || PAGE_REGS > 64) begin : g_bad
        $error("emspf_mapper: page register count must lie between 40 and 64");
    end

    emspf_pkg::emspf_state_t state_reg;
    emspf_pkg::emspf_state_t state_next;

    logic sel_ctrl;
    logic sel_ptr;
    logic sel_page;
    logic sel_test;
    logic prog_ok;
    logic in_range;
    logic page_acc;
    logic mem_we;
    logic [15:0] mem_wdata;
    logic [15:0] host_page;
    logic [15:0] map_page;
    logic dec_upper;
    logic dec_lower;
    logic [5:0] dec_index;
    logic [15:0] ctrl_view;
    logic [15:0] ptr_view;
    logic [15:0] test_view;
    logic en_ok;

    emspf_frame_dec u_dec (
        .i_addr(i_mem.addr),
        .i_base_select(state_reg.base_sel),
        .o_upper(dec_upper),
        .o_lower(dec_lower),
        .o_index(dec_index)
    );

    emspf_page_mem #(
        .DEPTH(PAGE_REGS),
        .WIDTH(16),
        .AW(6),
        .RESET_BASE(emspf_pkg::UPPER_RESET_BASE)
    ) u_mem (
        .i_clk(i_clk),
        .i_sys_rst(i_sys_rst),
        .i_we(mem_we),
        .i_waddr(state_reg.ptr),
        .i_wdata(mem_wdata),
        .i_host_addr(state_reg.ptr),
        .o_host_data(host_page),
        .i_map_addr(dec_index),
        .o_map_data(map_page)
    );

    // Port decode and access qualification.
    always_comb begin
        sel_ctrl = (i_io.addr == emspf_pkg::CTRL_PORT);
        sel_ptr = (i_io.addr == emspf_pkg::PTR_PORT);
        sel_page = (i_io.addr == emspf_pkg::PAGE_PORT);
        sel_test = (i_io.addr == emspf_pkg::TEST_PORT);
        prog_ok = (state_reg.frame_en != emspf_pkg::EMSPF_OFF);
        in_range = ({1'b0, state_reg.ptr} < REGS_N);
        page_acc = (i_io.rd || i_io.wr) && sel_page && prog_ok;
        mem_we = i_io.wr && sel_page && prog_ok && in_range;
        mem_wdata = i_io.wdata;
        mem_wdata[emspf_pkg::PAGE_RO_HI:emspf_pkg::PAGE_RO_LO] = 3'h0;
    end

    // Read-back views of the ports.
    always_comb begin
        ctrl_view = 16'h0000;
        ctrl_view[emspf_pkg::CTRL_INC_BIT] = state_reg.inc;
        ctrl_view[emspf_pkg::CTRL_LOC_HI:emspf_pkg::CTRL_LOC_LO] = state_reg.base_sel;
        ctrl_view[emspf_pkg::CTRL_EN_HI:emspf_pkg::CTRL_EN_LO] = state_reg.frame_en;
        ctrl_view[emspf_pkg::CTRL_APPLY_BIT] = state_reg.apply;
        ctrl_view[emspf_pkg::CTRL_RSV_HI:emspf_pkg::CTRL_RSV_LO] = state_reg.rsv;
        ptr_view = 16'h0000;
        ptr_view[emspf_pkg::PTR_HI:emspf_pkg::PTR_LO] = state_reg.ptr;
        if (state_reg.test_trig) begin
            ptr_view[emspf_pkg::TAP_HI:emspf_pkg::TAP_LO] = i_delay_tap_state;
        end
        test_view = 16'h0000;
        test_view[emspf_pkg::TEST_TRIG_BIT] = state_reg.test_trig;
    end

    // Next-state logic of the whole block.
    always_comb begin
        state_next = state_reg;
        en_ok = 1'b0;
        if (i_sys_rst) begin
            state_next = '0;
            state_next.frame_en = emspf_pkg::EMSPF_OFF;
        end else begin
            // Register writes.
            if (i_io.wr && sel_ctrl) begin
                state_next.inc = i_io.wdata[emspf_pkg::CTRL_INC_BIT];
                state_next.base_sel = i_io.wdata[emspf_pkg::CTRL_LOC_HI:emspf_pkg::CTRL_LOC_LO];
                state_next.frame_en = emspf_pkg::emspf_frame_en_t'(
                    i_io.wdata[emspf_pkg::CTRL_EN_HI:emspf_pkg::CTRL_EN_LO]);
                state_next.apply = i_io.wdata[emspf_pkg::CTRL_APPLY_BIT];
                state_next.rsv = i_io.wdata[emspf_pkg::CTRL_RSV_HI:emspf_pkg::CTRL_RSV_LO];
            end
            if (i_io.wr && sel_test) begin
                state_next.test_trig = i_io.wdata[emspf_pkg::TEST_TRIG_BIT];
            end
            if (i_io.wr && sel_ptr) begin
                state_next.ptr = i_io.wdata[emspf_pkg::PTR_HI:emspf_pkg::PTR_LO];
            end else if (page_acc && state_reg.inc) begin
                state_next.ptr = state_reg.ptr + 6'h01;
            end

            // Register reads answer two cycles after the strobe.
            state_next.rd_go = i_io.rd && (sel_ctrl || sel_ptr || sel_page || sel_test);
            state_next.rd_page = i_io.rd && sel_page && prog_ok && in_range;
            state_next.rd_hold = 16'h0000;
            if (sel_ctrl) begin
                state_next.rd_hold = ctrl_view;
            end else if (sel_ptr) begin
                state_next.rd_hold = ptr_view;
            end else if (sel_test) begin
                state_next.rd_hold = test_view;
            end
            state_next.rdata = state_reg.rd_page ? host_page : state_reg.rd_hold;
            state_next.rvalid = state_reg.rd_go;

            // Translation, first stage: window decode and page register lookup.
            state_next.m_valid = i_mem.valid;
            state_next.m_upper = dec_upper && state_reg.frame_en[1];
            state_next.m_lower = dec_lower
                && (state_reg.frame_en == emspf_pkg::EMSPF_ALL);
            state_next.m_off = i_mem.addr[emspf_pkg::OFF_W-1:0];
            state_next.m_rsv = state_reg.apply
                && (i_mem.addr[emspf_pkg::RSV_ADDR_HI:emspf_pkg::RSV_ADDR_LO]
                > state_reg.rsv);

            // Translation, second stage: enable check and physical address.
            en_ok = state_reg.m_lower
                || (state_reg.m_upper && map_page[emspf_pkg::PAGE_EN_BIT]);
            state_next.map.valid = state_reg.m_valid;
            state_next.map.hit = state_reg.m_valid && en_ok;
            state_next.map.external = state_reg.m_valid && en_ok
                && map_page[emspf_pkg::PAGE_EXT_BIT];
            state_next.map.reserved = state_reg.m_valid && state_reg.m_rsv;
            state_next.map.phys = {map_page[emspf_pkg::PAGE_NUM_HI:emspf_pkg::PAGE_NUM_LO],
                                   state_reg.m_off};
        end
    end

    always_ff @(posedge i_clk) begin
        state_reg <= state_next;
    end

    assign o_io_rdata = state_reg.rdata;
    assign o_io_rvalid = state_reg.rvalid;
    assign o_map = state_reg.map;
    assign o_delay_test_trigger = state_reg.test_trig;
endmodule : emspf_mapper
`default_nettype wire

// [tb/emspf_chk.sv]
// Port checker of the expanded-memory page mapper.
`timescale 1ns/1ps
`default_nettype none
module emspf_chk #(
    parameter int PAGE_REGS = 40
) (
    input wire logic i_clk,
    input wire logic i_sys_rst,
    input wire emspf_pkg::emspf_io_req_t i_io,
    input wire logic [15:0] o_io_rdata,
    input wire logic o_io_rvalid,
    input wire emspf_pkg::emspf_mem_req_t i_mem,
    input wire emspf_pkg::emspf_map_t o_map,
    input wire logic [emspf_pkg::TAP_W-1:0] i_delay_tap_state,
    input wire logic o_delay_test_trigger
);
    logic [1:0] en_reg;
    logic apply_reg;
    logic [6:0] rsv_reg;
    logic ctrl_wr;
    logic io_hit;
    assign ctrl_wr = i_io.wr && i_io.addr == emspf_pkg::CTRL_PORT;
    assign io_hit = i_io.rd && i_io.addr inside {emspf_pkg::CTRL_PORT, emspf_pkg::PTR_PORT,
        emspf_pkg::PAGE_PORT, emspf_pkg::TEST_PORT};
    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            en_reg <= 2'h0;
            apply_reg <= 1'h0;
            rsv_reg <= 7'h00;
        end else if (ctrl_wr) begin
            en_reg <= i_io.wdata[11:10];
            apply_reg <= i_io.wdata[7];
            rsv_reg <= i_io.wdata[6:0];
        end
    end
    default clocking @(posedge i_clk);
    endclocking
    default disable iff (i_sys_rst);
    sequence s_ptr_rd;
        i_io.rd && i_io.addr == emspf_pkg::PTR_PORT;
    endsequence
    sequence s_test_wr;
        i_io.wr && i_io.addr == emspf_pkg::TEST_PORT;
    endsequence
    property p_rd_lat;
        o_io_rvalid == $past(io_hit, 2);
    endproperty
    property p_ptr_ro;
        s_ptr_rd ##0 !o_delay_test_trigger |-> ##2 o_io_rdata[15:6] == 10'h000;
    endproperty
    property p_tap;
        s_ptr_rd ##0 o_delay_test_trigger |-> ##2 o_io_rdata[15:6] == $past(i_delay_tap_state, 2);
    endproperty
    property p_trig_set;
        s_test_wr |=> o_delay_test_trigger == $past(i_io.wdata[8]);
    endproperty
    property p_trig_hold;
        !(i_io.wr && i_io.addr == emspf_pkg::TEST_PORT) |=> $stable(o_delay_test_trigger);
    endproperty
    property p_map_lat;
        o_map.valid == $past(i_mem.valid, 2);
    endproperty
    property p_phys_off;
        o_map.valid && o_map.hit |-> o_map.phys[13:0] == $past(i_mem.addr[13:0], 2);
    endproperty
    property p_high_miss;
        i_mem.valid && i_mem.addr[23:20] != 4'h0 |-> ##2 !o_map.hit;
    endproperty
    property p_off_miss;
        i_mem.valid && !ctrl_wr && en_reg < 2'h2 |-> ##2 o_map.valid && !o_map.hit;
    endproperty
    property p_rsv;
        i_mem.valid && !ctrl_wr |-> ##2
            o_map.reserved == $past(apply_reg && i_mem.addr[23:17] > rsv_reg, 2);
    endproperty
    a_rd_lat: assert property (p_rd_lat) else $error("read answer timing wrong");
    a_ptr_ro: assert property (p_ptr_ro) else $error("pointer upper bits not zero");
    a_tap: assert property (p_tap) else $error("tap state not shown");
    a_trig_set: assert property (p_trig_set) else $error("test trigger not loaded");
    a_trig_hold: assert property (p_trig_hold) else $error("test trigger moved");
    a_map_lat: assert property (p_map_lat) else $error("map answer timing wrong");
    a_phys_off: assert property (p_phys_off) else $error("page offset wrong");
    a_high_miss: assert property (p_high_miss) else $error("hit above 1 Mbyte");
    a_off_miss: assert property (p_off_miss) else $error("hit with frames off");
    a_rsv: assert property (p_rsv) else $error("reserved flag wrong");
endmodule : emspf_chk
bind emspf_mapper emspf_chk #(.PAGE_REGS(PAGE_REGS)) u_chk (.i_clk(i_clk), .i_sys_rst(i_sys_rst),
    .i_io(i_io), .o_io_rdata(o_io_rdata), .o_io_rvalid(o_io_rvalid), .i_mem(i_mem),
    .o_map(o_map), .i_delay_tap_state(i_delay_tap_state),
    .o_delay_test_trigger(o_delay_test_trigger));
`default_nettype wire

// [tb/emspf_host.sv]
// Host processor model issuing I/O port and memory cycles.
`timescale 1ns/1ps
`default_nettype none
module emspf_host (
    input wire logic i_clk,
    input wire logic [15:0] i_io_rdata,
    input wire logic i_io_rvalid,
    input wire emspf_pkg::emspf_map_t i_map,
    output var emspf_pkg::emspf_io_req_t o_io,
    output var emspf_pkg::emspf_mem_req_t o_mem
);
    initial begin
        o_io = '0;
        o_mem = '0;
    end
    task automatic io_wr(input logic [15:0] a, input logic [15:0] d);
        @(negedge i_clk);
        o_io = {2'b01, a, d};
        @(negedge i_clk);
        o_io = {2'b00, ~a, ~d};
    endtask : io_wr
    task automatic io_rd(input logic [15:0] a, output logic [15:0] d, output logic v);
        @(negedge i_clk);
        o_io = {2'b10, a, 16'h0000};
        @(negedge i_clk);
        o_io = {2'b00, ~a, 16'hFFFF};
        d = 16'h0000;
        v = 1'b0;
        for (int n = 0; n < 4 && !v; n++) begin
            if (i_io_rvalid === 1'b1) begin
                v = 1'b1;
                d = i_io_rdata;
            end else begin
                @(negedge i_clk);
            end
        end
    endtask : io_rd
    task automatic mem(input logic [23:0] a, output emspf_pkg::emspf_map_t m);
        @(negedge i_clk);
        o_mem = {1'b1, a};
        @(negedge i_clk);
        o_mem = {1'b0, ~a};
        m = '0;
        for (int n = 0; n < 4 && !m.valid; n++) begin
            if (i_map.valid) m = i_map;
            else @(negedge i_clk);
        end
    endtask : mem
endmodule : emspf_host
`default_nettype wire

// [tb/tb.sv]
// Self-checking testbench of the expanded-memory page mapper.
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, exp) begin checked++; if ((got) !== (exp)) begin bad_count++; \
    $display("ERROR %0t: got %h expected %h", $time, got, exp); end end
module tb;
    localparam logic [15:0] CTRL = emspf_pkg::CTRL_PORT;
    localparam logic [15:0] PTR = emspf_pkg::PTR_PORT;
    localparam logic [15:0] PAGE = emspf_pkg::PAGE_PORT;
    localparam logic [15:0] TEST = emspf_pkg::TEST_PORT;
    logic clk = 1'b0;
    logic sys_rst = 1'b1;
    logic [9:0] tap_state = 10'h2A5;
    emspf_pkg::emspf_io_req_t io_req;
    emspf_pkg::emspf_mem_req_t mem_req;
    emspf_pkg::emspf_map_t map;
    emspf_pkg::emspf_map_t res;
    logic [15:0] io_rdata;
    logic io_rvalid;
    logic test_trigger;
    logic [5:0] win;
    logic [15:0] rd_word;
    logic rd_seen;
    int exp_reg;
    int bad_count = 0;
    int checked = 0;
    always #2.5 clk = ~clk;
    emspf_mapper #(.PAGE_REGS(40)) dut (.i_clk(clk), .i_sys_rst(sys_rst), .i_io(io_req),
        .o_io_rdata(io_rdata), .o_io_rvalid(io_rvalid), .i_mem(mem_req), .o_map(map),
        .i_delay_tap_state(tap_state), .o_delay_test_trigger(test_trigger));
    emspf_host host (.i_clk(clk), .i_io_rdata(io_rdata), .i_io_rvalid(io_rvalid), .i_map(map),
        .o_io(io_req), .o_mem(mem_req));
    function automatic logic [15:0] pg(input int i);
        if (i == 39) return 16'h0327;
        if (i >= 32) return 16'h8300 + 16'(i);
        return 16'h0200 + 16'(i) + (i == 8 ? 16'h0800 : 16'h0000);
    endfunction : pg
    task automatic rd_chk(input logic [15:0] a, input logic [15:0] e);
        logic [15:0] d;
        logic v;
        host.io_rd(a, d, v);
        `CHK(v, 1'b1)
        `CHK(d, e)
    endtask : rd_chk
    task automatic chk_map(input logic [23:0] a, input int r, input logic en);
        logic [15:0] p;
        logic eh;
        emspf_pkg::emspf_map_t m;
        p = pg(r);
        eh = en && (r < 32 || p[15]);
        host.mem(a, m);
        `CHK(m.valid, 1'b1)
        `CHK(m.hit, eh)
        `CHK(m.external, eh && p[11])
        if (eh) `CHK(m.phys, {p[11:0], a[13:0]})
    endtask : chk_map
    task automatic tally_and_finish();
        $display("Comparisons %0d, mismatches %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : tally_and_finish
    initial begin
        #50000;
        bad_count++;
        $display("ERROR %0t: watchdog expired", $time);
        tally_and_finish();
    end
    initial begin
        repeat (2) @(negedge clk);
        sys_rst = 1'b0;
        rd_chk(CTRL, 16'h0000);
        rd_chk(PTR, 16'h0000);
        host.io_wr(PTR, 16'h0020);
        host.io_wr(PAGE, 16'h8001);
        rd_chk(PAGE, 16'h0000);
        host.io_wr(CTRL, 16'hFFFF);
        rd_chk(CTRL, 16'hECFF);
        host.io_wr(PTR, 16'hFFE7);
        rd_chk(PTR, 16'h0027);
        host.io_wr(TEST, 16'hFFFF);
        `CHK(test_trigger, 1'b1)
        rd_chk(TEST, 16'h0100);
        rd_chk(PTR, {tap_state, 6'h27});
        host.io_wr(TEST, 16'h0000);
        `CHK(test_trigger, 1'b0)
        host.io_wr(CTRL, 16'h8C00);
        host.io_wr(PTR, 16'h0020);
        rd_chk(PAGE, 16'h0000);
        host.io_wr(PTR, 16'h0000);
        for (int i = 0; i < 40; i++) host.io_wr(PAGE, pg(i) | 16'h7000);
        rd_chk(PTR, 16'h0028);
        host.io_wr(PTR, 16'h0000);
        for (int i = 0; i < 40; i++) rd_chk(PAGE, pg(i));
        host.io_wr(CTRL, 16'h0C00);
        host.io_wr(PTR, 16'h0005);
        rd_chk(PAGE, pg(5));
        rd_chk(PAGE, pg(5));
        rd_chk(PTR, 16'h0005);
        for (int s = 0; s < 4; s++) begin
            host.io_wr(CTRL, 16'h0800 | 16'(s << 13));
            for (int k = -1; k < 9; k++) begin
                win = 6'(49 + s + k);
                exp_reg = 32 + ((int'(win) - 56) & 7);
                chk_map({4'h0, win, 14'h1A5}, exp_reg, k >= 0 && k < 8);
            end
        end
        host.io_wr(CTRL, 16'h0C00);
        for (int w = 8; w < 40; w++) chk_map({4'h0, 6'(w), 14'h2C3}, w % 32, 1'b1);
        for (int f = 0; f < 4; f++) begin
            host.io_wr(CTRL, 16'(f << 10));
            chk_map(24'h020005, 8, f == 3);
            chk_map(24'h0E0005, 32, f >= 2);
        end
        host.io_wr(CTRL, 16'h0087);
        host.mem(24'h100000, res);
        `CHK(res.reserved, 1'b1)
        host.mem(24'h0FFFFF, res);
        `CHK(res.reserved, 1'b0)
        host.mem(24'hFE0000, res);
        `CHK(res.reserved, 1'b1)
        host.io_wr(CTRL, 16'h0007);
        host.mem(24'h100000, res);
        `CHK(res.reserved, 1'b0)
        host.io_wr(16'h6873, 16'hFFFF);
        host.io_rd(16'h6873, rd_word, rd_seen);
        `CHK(rd_seen, 1'b0)
        rd_chk(CTRL, 16'h0007);
        tally_and_finish();
    end
endmodule : tb
`default_nettype wire
